/* pkg/epg_pkg.sv */
package epg_pkg;
  // Register byte offsets on the APB port.
  localparam logic [7:0] EPG_MODE_OFFSET = 8'h00;
  localparam logic [7:0] EPG_STATUS_OFFSET = 8'h04;
  localparam logic [7:0] EPG_PHASE_OFFSET = 8'h08;
  // Mode register field positions.
  localparam int EPG_GP_LOW_POS = 0;
  localparam int EPG_GP_HIGH_POS = 1;
  localparam int EPG_PIN_FUNC_POS = 2;
  localparam int EPG_CHOP_POS = 3;
  localparam int EPG_ALT_POS = 4;
  localparam int EPG_MODE_WIDTH = 5;
  // Mode register reset value: analog input use, all drive off.
  localparam logic [4:0] EPG_MODE_RESET = 5'h00;
  // Excitation half period in master clock cycles.
  localparam logic [15:0] EPG_HALF_PERIOD_RESET = 16'h0100;
  // Non-overlap interval in master clock cycles.
  localparam logic [15:0] EPG_GAP_CYCLES = 16'h0001;
  // Excitation sequencer states.
  typedef enum logic [1:0] {
    EPG_NORMAL,
    EPG_GAP_TO_REV,
    EPG_REVERSED,
    EPG_GAP_TO_NORM
  } epg_state_e;
endpackage

/* src/epg_outputs.sv */
// The implementer's own choices: the APB register port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module epg_outputs import epg_pkg::*; (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Dual-purpose pins, enables active low.
  output logic gp_pos_out,
  output logic gp_pos_oe_n,
  output logic gp_neg_out,
  output logic gp_neg_oe_n,
  // Excitation reversal pair.
  output logic excite_phase,
  output logic excite_phase_inverted
);

  logic [4:0] mode_reg;
  logic [15:0] half_period_reg;
  logic [15:0] count_reg;
  epg_state_e state_reg;
  epg_state_e state_next;
  logic ac_on;
  logic setup;
  logic acc;

  assign setup = psel && !penable;
  assign acc = psel && penable;
  assign ac_on = mode_reg[EPG_ALT_POS] && mode_reg[EPG_CHOP_POS];

  // Register writes take effect at the access edge; a zero half period is held at one.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mode_reg <= EPG_MODE_RESET;
      half_period_reg <= EPG_HALF_PERIOD_RESET;
    end else if (acc && pready && pwrite) begin
      if (paddr == EPG_MODE_OFFSET) begin
        mode_reg <= pwdata[EPG_MODE_WIDTH-1:0];
      end else if (paddr == EPG_PHASE_OFFSET) begin
        half_period_reg <= (pwdata[15:0] == 16'h0000) ? 16'h0001 : pwdata[15:0];
      end
    end
  end

  // Slave answers one cycle after setup, so each transfer takes two cycles.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= setup;
      pslverr <= setup && (paddr != EPG_MODE_OFFSET) && (paddr != EPG_STATUS_OFFSET)
                 && (paddr != EPG_PHASE_OFFSET);
      prdata <= 32'h0000_0000;
      if (setup && !pwrite) begin
        case (paddr)
          EPG_MODE_OFFSET: prdata <= {27'h0000000, mode_reg};
          EPG_STATUS_OFFSET: prdata <= {28'h0000000, ac_on, 1'b0, state_reg};
          EPG_PHASE_OFFSET: prdata <= {16'h0000, half_period_reg};
          default: prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Sequencer: every swap passes through a gap state where both outputs are low.
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      EPG_NORMAL: begin
        if (ac_on && count_reg >= half_period_reg - 16'h0001) begin
          state_next = EPG_GAP_TO_REV;
        end
      end
      EPG_GAP_TO_REV: begin
        // A drop of the enables here goes straight back to normal, so the gap stays one cycle.
        state_next = ac_on ? EPG_REVERSED : EPG_NORMAL;
      end
      EPG_REVERSED: begin
        if (!ac_on || count_reg >= half_period_reg - 16'h0001) begin
          state_next = EPG_GAP_TO_NORM;
        end
      end
      EPG_GAP_TO_NORM: begin
        state_next = EPG_NORMAL;
      end
      default: state_next = EPG_NORMAL;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= EPG_NORMAL;
    end else begin
      state_reg <= state_next;
    end
  end

  // Dwell counter restarts on each state change.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count_reg <= 16'h0000;
    end else if (state_next != state_reg || !ac_on) begin
      count_reg <= 16'h0000;
    end else begin
      count_reg <= count_reg + 16'h0001;
    end
  end

  // Outputs registered from the next state, so both are low together in gap states.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      excite_phase <= 1'b1;
      excite_phase_inverted <= 1'b0;
    end else begin
      excite_phase <= (state_next == EPG_NORMAL);
      excite_phase_inverted <= (state_next == EPG_REVERSED);
    end
  end

  // Pins released while in analog mode, which also protects the analog source.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      gp_pos_out <= 1'b0;
      gp_neg_out <= 1'b0;
      gp_pos_oe_n <= 1'b1;
      gp_neg_oe_n <= 1'b1;
    end else begin
      gp_pos_oe_n <= !mode_reg[EPG_PIN_FUNC_POS];
      gp_neg_oe_n <= !mode_reg[EPG_PIN_FUNC_POS];
      gp_pos_out <= mode_reg[EPG_PIN_FUNC_POS] & mode_reg[EPG_GP_HIGH_POS];
      gp_neg_out <= mode_reg[EPG_PIN_FUNC_POS] & mode_reg[EPG_GP_LOW_POS];
    end
  end

endmodule
`default_nettype wire

/* test/epg_bridge_model.sv */
`timescale 1ns/10ps
`default_nettype none
module epg_bridge (
  // Excitation pair in, short flag out.
  input wire logic clk, rst, excite_phase, excite_phase_inverted,
  output logic fault
);
  // overlapping switch legs
  // Both legs closed short the bridge supply, so the flag latches until reset.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) fault <= 1'h0;
    else fault <= fault | (excite_phase & excite_phase_inverted);
  end
endmodule
`default_nettype wire

/* test/epg_asserts.sv */
`timescale 1ns/10ps
`default_nettype none
module epg_chk import epg_pkg::*; (
  // Watched block ports.
  input wire logic clk, rst, psel, penable, pready, pslverr,
  input wire logic [7:0] paddr,
  input wire logic gp_pos_out, gp_pos_oe_n, gp_neg_out, gp_neg_oe_n,
  input wire logic excite_phase, excite_phase_inverted
);
  // Short aliases for the excitation pair.
  wire logic p = excite_phase;
  wire logic q = excite_phase_inverted;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_no_overlap: assert property (!(p && q)) else $error("pair overlap");
  a_gap_single: assert property (!p && !q |=> p || q) else $error("gap too long");
  a_rise_normal: assert property ($rose(p) |-> !$past(q)) else $error("no gap");
  a_rise_reversed: assert property ($rose(q) |-> !$past(p) && $past(p, 2))
    else $error("no gap");
  a_pins_paired: assert property (gp_pos_oe_n == gp_neg_oe_n) else $error("pins split");
  a_float_low: assert property (gp_pos_oe_n |-> !gp_pos_out && !gp_neg_out)
    else $error("pins driven");
  a_ready_one: assert property (psel && !penable |=> pready ##1 !pready) else $error("no ready");
  a_err_map: assert property (pready |-> pslverr == (paddr > 8'h08 || paddr[1:0] != 2'h0))
    else $error("bad error");
endmodule
bind epg_outputs epg_chk i_chk (.*);
`default_nettype wire

/* test/tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
module tb_top import epg_pkg::*; ;
  logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr, flt, err;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic gp_pos_out, gp_pos_oe_n, gp_neg_out, gp_neg_oe_n, excite_phase, excite_phase_inverted;
  int n_fail = 0, n_checks = 0, k;
  // Clock of 50 ns period.
  always #25 clk = ~clk;
  epg_outputs i_dut (.*);
  epg_bridge i_brg (.*, .fault(flt));
  task automatic chk(input logic [31:0] v, e);
    n_checks++;
    if (v !== e) begin
      n_fail++;
      $display("wrong value at %0t: %h %h", $time, v, e);
    end
  endtask
  // APB transfer plus one idle cycle, so a new setup never lands on a release.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    {psel, pwrite, paddr, pwdata} <= {1'h1, w, a, d};
    @(posedge clk);
    penable <= 1'h1;
    do @(posedge clk); while (pready !== 1'h1);
    {err, rd, psel, penable} <= {pslverr, prdata, 2'h0};
    @(posedge clk);
  endtask
  task final_report;
    $display("checks %0d fails %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Watchdog; the tests need under a hundred cycles.
  initial begin
    #60000;
    n_fail++;
    final_report;
  end
  // Main sequence.
  initial begin
    repeat (5) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    chk({gp_pos_oe_n, gp_pos_out, excite_phase, excite_phase_inverted}, 4'ha);
    for (k = 4; k < 8; k++) begin
      apb(1, EPG_MODE_OFFSET, k);
      @(posedge clk);
      chk({gp_pos_oe_n, gp_pos_out, gp_neg_oe_n, gp_neg_out}, {1'h0, k[1], 1'h0, k[0]});
    end
    apb(1, 8'h0c, 0);
    chk(err, 1'h1);
    apb(1, EPG_PHASE_OFFSET, 3);
    apb(0, EPG_PHASE_OFFSET, 0);
    chk(rd, 3);
    apb(1, EPG_MODE_OFFSET, 24);
    do @(posedge clk); while (excite_phase_inverted !== 1'h1);
    for (k = 0; excite_phase_inverted === 1'h1; k++) begin
      chk(excite_phase, 1'h0);
      @(posedge clk);
    end
    chk(k, 3);
    chk({gp_pos_oe_n, gp_neg_oe_n}, 2'h3);
    apb(0, EPG_STATUS_OFFSET, 0);
    chk(rd[3], 1'h1);
    apb(1, EPG_MODE_OFFSET, 8);
    apb(0, EPG_MODE_OFFSET, 0);
    chk(rd, 8);
    apb(0, 8'h0c, 0);
    chk({err, rd}, 33'h1_0000_0000);
    apb(1, EPG_PHASE_OFFSET, 0);
    apb(0, EPG_PHASE_OFFSET, 0);
    chk(rd, 1);
    repeat (4) @(posedge clk);
    chk({excite_phase, excite_phase_inverted}, 2'h2);
    chk(flt, 1'h0);
    final_report;
  end
endmodule
`default_nettype wire
